// ==== servo_stop_pkg.sv ====
// Constants, register map and state codes for the servo enable/stop sequencer
package servo_stop_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned CYCLES_PER_MS = CLK_HZ / MS_PER_S;

  // Register byte offsets on the APB
  localparam logic [7:0] OFS_DISABLE_STOP_METHOD = 8'h00;
  localparam logic [7:0] OFS_ESTOP_STOP_METHOD = 8'h04;
  localparam logic [7:0] OFS_FAST_STOP_TIME_MS = 8'h08;
  localparam logic [7:0] OFS_SLOW_STOP_TIME_MS = 8'h0C;
  localparam logic [7:0] OFS_DRIVE_CONTROL = 8'h10;
  localparam logic [7:0] OFS_RATED_SPEED = 8'h14;
  localparam logic [7:0] OFS_DRIVE_STATUS = 8'h18;
  localparam logic [7:0] OFS_INT_STATUS = 8'h1C;
  localparam logic [7:0] OFS_INT_CLEAR = 8'h20;
  localparam logic [7:0] OFS_INT_ENABLE = 8'h24;

  // Reset values
  localparam logic [2:0] RST_DISABLE_STOP_METHOD = 3'h0;
  localparam logic [2:0] RST_ESTOP_STOP_METHOD = 3'h0;
  localparam logic [2:0] RST_FAULT_STOP_METHOD = 3'h0;
  localparam logic [15:0] RST_FAST_STOP_TIME_MS = 16'h01F4;
  localparam logic [15:0] RST_SLOW_STOP_TIME_MS = 16'h03E8;
  localparam logic [15:0] RST_RATED_SPEED = 16'h0BB8;

  // Highest legal stop method codes
  localparam logic [2:0] MAX_DISABLE_METHOD = 3'h2;
  localparam logic [2:0] MAX_ESTOP_METHOD = 3'h4;

  // Stop method codes
  localparam logic [2:0] STOP_COAST = 3'h0;
  localparam logic [2:0] STOP_FAST_OFF = 3'h1;
  localparam logic [2:0] STOP_SLOW_OFF = 3'h2;
  localparam logic [2:0] STOP_FAST_HOLD = 3'h3;
  localparam logic [2:0] STOP_SLOW_HOLD = 3'h4;

  // Control register field positions
  localparam int unsigned CTRL_SW_RUN_BIT = 0;
  localparam int unsigned CTRL_SW_ESTOP_BIT = 1;
  localparam int unsigned CTRL_FAULT_METHOD_LSB = 4;

  // Interrupt status bits
  localparam int unsigned INT_ENABLED_BIT = 0;
  localparam int unsigned INT_STOP_START_BIT = 1;
  localparam int unsigned INT_STOP_DONE_BIT = 2;
  localparam int unsigned INT_CMD_REJECT_BIT = 3;
  localparam int unsigned INT_BITS = 4;

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_OFF = 4'b0001,
    ST_RUN = 4'b0010,
    ST_RAMP = 4'b0100,
    ST_HOLD = 4'b1000
  } seq_state_t;

endpackage

// ==== servo_enable_stop_sequencer.sv ====
// Servo power stage enable and stop sequencer with APB register file
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Run-enable from pin or register enables drive
// - Commands ignored until command-ready is asserted
// - Disable, fault or emergency stop start stopping
// - Each stop trigger has its own method
// - Disable method 0..2, reset 0
// - Emergency method 0..4, reset 0
// - Coast switches power output off immediately
// - Ramp stops keep motor energized to zero
// - Ramp-then-off drops enable at zero speed
// - Ramp-and-hold stays locked until enable removed or a fault with coast method
// - Fast ramp time in ms, reset 500
// - Slow ramp time in ms, reset 1000
// - Ramp duration scales with speed over rated
module servo_enable_stop_sequencer
  import servo_stop_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic reset_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic pready_out,
  output logic pslverr_out,
  output logic [31:0] prdata_out,
  // Drive pins and fault source
  input wire logic run_enable_function_in,
  input wire logic emergency_stop_function_in,
  input wire logic fault_in,
  // Host command port, same clock
  input wire logic cmd_valid_in,
  input wire logic [1:0] cmd_kind_in,
  input wire logic [15:0] cmd_value_in,
  // Drive outputs
  output logic command_ready_output_out,
  output logic power_stage_on_out,
  output logic [15:0] speed_ref_out,
  output logic cmd_strobe_out,
  output logic [1:0] cmd_kind_out,
  output logic [15:0] cmd_value_out,
  output logic irq_out
);

  localparam logic [1:0] KIND_SPEED = 2'h1;
  localparam logic [31:0] CPM = CYCLES_PER_MS;

  typedef struct packed {
    seq_state_t st;
    logic run_meta;
    logic run_sync;
    logic estop_meta;
    logic estop_sync;
    logic [2:0] dis_method;
    logic [2:0] estop_method;
    logic [2:0] fault_method;
    logic [15:0] fast_ms;
    logic [15:0] slow_ms;
    logic [15:0] rated;
    logic sw_run;
    logic sw_estop;
    logic [INT_BITS-1:0] int_stat;
    logic [INT_BITS-1:0] int_en;
    logic signed [15:0] speed;
    logic ramp_hold;
    logic [31:0] acc;
    logic [31:0] ramp_lim;
    logic cmd_strobe;
    logic [1:0] cmd_kind;
    logic [15:0] cmd_value;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
    logic ready;
    logic power;
  } seq_regs_t;

  localparam seq_regs_t RESET_REGS = '{
    st: ST_OFF,
    dis_method: RST_DISABLE_STOP_METHOD,
    estop_method: RST_ESTOP_STOP_METHOD,
    fault_method: RST_FAULT_STOP_METHOD,
    fast_ms: RST_FAST_STOP_TIME_MS,
    slow_ms: RST_SLOW_STOP_TIME_MS,
    rated: RST_RATED_SPEED,
    default: '0
  };

  seq_regs_t r;
  seq_regs_t next_r;

  // Decoded trigger and method values used by the state logic
  logic run_en;
  logic estop_act;
  logic trig_any;
  logic [2:0] trig_method;
  logic [15:0] trig_ms;
  logic apb_write;
  logic apb_read;
  logic [INT_BITS-1:0] int_set;
  logic [INT_BITS-1:0] int_clr;
  logic addr_ok;
  logic [31:0] rd_word;

  // Effective enable and emergency request, pin or register source
  always_comb begin
    run_en = r.run_sync | r.sw_run;
    estop_act = r.estop_sync | r.sw_estop;
    trig_any = fault_in | estop_act | ~run_en;
    // Fault wins over emergency, emergency over plain disable
    if (fault_in) begin
      trig_method = r.fault_method;
    end else if (estop_act) begin
      trig_method = r.estop_method;
    end else begin
      trig_method = r.dis_method;
    end
    if (trig_method == STOP_SLOW_OFF || trig_method == STOP_SLOW_HOLD) begin
      trig_ms = r.slow_ms;
    end else begin
      trig_ms = r.fast_ms;
    end
  end

  // APB decode; a write lands only on the edge where pready is seen high
  always_comb begin
    apb_write = psel_in & penable_in & pwrite_in & r.pready;
    apb_read = psel_in & penable_in & ~pwrite_in & ~r.pready;
    unique case (paddr_in)
      OFS_DISABLE_STOP_METHOD,
      OFS_ESTOP_STOP_METHOD,
      OFS_FAST_STOP_TIME_MS,
      OFS_SLOW_STOP_TIME_MS,
      OFS_DRIVE_CONTROL,
      OFS_RATED_SPEED,
      OFS_DRIVE_STATUS,
      OFS_INT_STATUS,
      OFS_INT_CLEAR,
      OFS_INT_ENABLE: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
    rd_word = 32'h0000_0000;
    unique case (paddr_in)
      OFS_DISABLE_STOP_METHOD: rd_word = {29'h0, r.dis_method};
      OFS_ESTOP_STOP_METHOD: rd_word = {29'h0, r.estop_method};
      OFS_FAST_STOP_TIME_MS: rd_word = {16'h0, r.fast_ms};
      OFS_SLOW_STOP_TIME_MS: rd_word = {16'h0, r.slow_ms};
      OFS_DRIVE_CONTROL: rd_word = {25'h0, r.fault_method, 2'h0, r.sw_estop, r.sw_run};
      OFS_RATED_SPEED: rd_word = {16'h0, r.rated};
      OFS_DRIVE_STATUS: rd_word = {r.speed, 8'h0, 2'h0, r.power, r.ready, r.st};
      OFS_INT_STATUS: rd_word = {28'h0, r.int_stat};
      OFS_INT_ENABLE: rd_word = {28'h0, r.int_en};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Whole next state of the block
  always_comb begin
    next_r = r;
    int_set = '0;
    int_clr = '0;
    next_r.cmd_strobe = 1'b0;

    // Two-stage synchronisers for the pin inputs
    next_r.run_meta = run_enable_function_in;
    next_r.run_sync = r.run_meta;
    next_r.estop_meta = emergency_stop_function_in;
    next_r.estop_sync = r.estop_meta;

    // Bus handshake: one wait state, then answer
    next_r.pready = psel_in & penable_in & ~r.pready;
    next_r.pslverr = psel_in & penable_in & ~r.pready & ~addr_ok;
    if (apb_read) begin
      next_r.prdata = addr_ok ? rd_word : 32'h0000_0000;
    end

    // Register writes; out-of-range method codes are dropped, old value kept
    if (apb_write) begin
      unique case (paddr_in)
        OFS_DISABLE_STOP_METHOD: begin
          if (pwdata_in[15:0] <= {13'h0, MAX_DISABLE_METHOD}) begin
            next_r.dis_method = pwdata_in[2:0];
          end
        end
        OFS_ESTOP_STOP_METHOD: begin
          if (pwdata_in[15:0] <= {13'h0, MAX_ESTOP_METHOD}) begin
            next_r.estop_method = pwdata_in[2:0];
          end
        end
        OFS_FAST_STOP_TIME_MS: next_r.fast_ms = pwdata_in[15:0];
        OFS_SLOW_STOP_TIME_MS: next_r.slow_ms = pwdata_in[15:0];
        OFS_DRIVE_CONTROL: begin
          next_r.sw_run = pwdata_in[CTRL_SW_RUN_BIT];
          next_r.sw_estop = pwdata_in[CTRL_SW_ESTOP_BIT];
          if (pwdata_in[CTRL_FAULT_METHOD_LSB +: 3] <= MAX_ESTOP_METHOD) begin
            next_r.fault_method = pwdata_in[CTRL_FAULT_METHOD_LSB +: 3];
          end
        end
        OFS_RATED_SPEED: next_r.rated = pwdata_in[15:0];
        OFS_INT_CLEAR: int_clr = pwdata_in[INT_BITS-1:0];
        OFS_INT_ENABLE: next_r.int_en = pwdata_in[INT_BITS-1:0];
        default: ;
      endcase
    end

    // Sequencer
    unique case (r.st)
      ST_OFF: begin
        next_r.speed = '0;
        if (run_en && !estop_act && !fault_in) begin
          next_r.st = ST_RUN;
          int_set[INT_ENABLED_BIT] = 1'b1;
        end
      end
      ST_RUN: begin
        if (trig_any) begin
          int_set[INT_STOP_START_BIT] = 1'b1;
          next_r.ramp_hold = trig_method == STOP_FAST_HOLD || trig_method == STOP_SLOW_HOLD;
          // Limit of the tick accumulator: ramp ms times cycles per ms
          next_r.ramp_lim = {16'h0, trig_ms} * CPM;
          next_r.acc = '0;
          if (trig_method == STOP_COAST) begin
            next_r.st = ST_OFF;
            next_r.speed = '0;
            int_set[INT_STOP_DONE_BIT] = 1'b1;
          end else begin
            next_r.st = ST_RAMP;
          end
        end else if (cmd_valid_in) begin
          // Accepted only while command-ready already shows high
          next_r.cmd_strobe = r.ready;
          next_r.cmd_kind = cmd_kind_in;
          next_r.cmd_value = cmd_value_in;
          if (r.ready && cmd_kind_in == KIND_SPEED) begin
            next_r.speed = cmd_value_in;
          end
          int_set[INT_CMD_REJECT_BIT] = ~r.ready;
        end
      end
      ST_RAMP: begin
        // A coast request from a fault or emergency cuts the ramp short
        if ((fault_in && r.fault_method == STOP_COAST) || (estop_act && r.estop_method == STOP_COAST)) begin
          next_r.st = ST_OFF;
          next_r.speed = '0;
          int_set[INT_STOP_DONE_BIT] = 1'b1;
        end else if (r.speed == 16'sh0000 || r.ramp_lim == 32'h0 || r.rated == 16'h0) begin
          // Zero time or zero rated speed means an instant stop
          next_r.speed = '0;
          next_r.st = r.ramp_hold ? ST_HOLD : ST_OFF;
          int_set[INT_STOP_DONE_BIT] = 1'b1;
        end else if (r.acc + {16'h0, r.rated} >= r.ramp_lim) begin
          // One speed unit toward zero per rated/limit crossing gives a straight line
          next_r.acc = r.acc + {16'h0, r.rated} - r.ramp_lim;
          next_r.speed = (r.speed > 16'sh0000) ? r.speed - 16'sh0001 : r.speed + 16'sh0001;
        end else begin
          next_r.acc = r.acc + {16'h0, r.rated};
        end
        int_set[INT_CMD_REJECT_BIT] = cmd_valid_in;
      end
      ST_HOLD: begin
        // Locked at zero speed; dropping the enable or a fault with coast method releases it
        next_r.speed = '0;
        if (!run_en || (fault_in && r.fault_method == STOP_COAST)) begin
          next_r.st = ST_OFF;
        end
        int_set[INT_CMD_REJECT_BIT] = cmd_valid_in;
      end
      default: begin
        next_r.st = ST_OFF;
        next_r.speed = '0;
      end
    endcase

    // Outputs follow the next state so they appear with it
    next_r.ready = next_r.st == ST_RUN;
    next_r.power = next_r.st != ST_OFF;

    // Sticky status: a set in the same cycle as a clear wins
    next_r.int_stat = (r.int_stat & ~int_clr) | int_set;
    next_r.irq = |(next_r.int_stat & next_r.int_en);
  end

  // Single state register
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      r <= RESET_REGS;
    end else begin
      r <= next_r;
    end
  end

  // Every output is a flop of the state
  assign pready_out = r.pready;
  assign pslverr_out = r.pslverr;
  assign prdata_out = r.prdata;
  assign command_ready_output_out = r.ready;
  assign power_stage_on_out = r.power;
  assign speed_ref_out = r.speed;
  assign cmd_strobe_out = r.cmd_strobe;
  assign cmd_kind_out = r.cmd_kind;
  assign cmd_value_out = r.cmd_value;
  assign irq_out = r.irq;

endmodule

`default_nettype wire

// ==== host_model.sv ====
// Host controller model: run enable, emergency stop and commands
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk_in,
  input wire logic run_req_in,
  input wire logic estop_req_in,
  input wire logic cmd_req_in,
  input wire logic [1:0] kind_in,
  input wire logic [15:0] value_in,
  output logic run_enable_out,
  output logic estop_out,
  output logic cmd_valid_out,
  output logic [1:0] kind_out,
  output logic [15:0] value_out
);
  // Idle values at time zero
  initial begin
    run_enable_out = 1'h0;
    estop_out = 1'h0;
    cmd_valid_out = 1'h0;
    kind_out = 2'h3;
    value_out = 16'h0000;
  end
  // Pins follow requests one edge late; stale command data is inverted so it never looks reused
  always @(posedge clk_in) begin
    run_enable_out <= run_req_in;
    estop_out <= estop_req_in;
    cmd_valid_out <= cmd_req_in;
    kind_out <= cmd_req_in ? kind_in : ~kind_out;
    value_out <= cmd_req_in ? value_in : ~value_out;
  end
endmodule
`default_nettype wire

// ==== servo_stop_assertions.sv ====
// Port checker for the servo enable and stop sequencer
`timescale 1ns/1ps
`default_nettype none
module servo_stop_checker (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic emergency_stop_function_in,
  input wire logic fault_in,
  input wire logic cmd_valid_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic command_ready_output_out,
  input wire logic power_stage_on_out,
  input wire logic [15:0] speed_ref_out,
  input wire logic cmd_strobe_out,
  input wire logic [1:0] cmd_kind_out,
  input wire logic [15:0] cmd_value_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  logic signed [15:0] prev_speed;
  logic signed [15:0] cur;
  logic prev_power;
  assign cur = speed_ref_out;
  // Last cycle's speed, so a ramp may move only one unit a tick
  always_ff @(posedge core_clk_in or posedge reset_in) begin
    if (reset_in) begin
      prev_speed <= 16'sh0000;
      prev_power <= 1'h0;
    end else begin
      prev_speed <= speed_ref_out;
      prev_power <= power_stage_on_out;
    end
  end
  apb_wait_a: assert property (psel_in && penable_in && !pready_out |=> pready_out ##1 !pready_out)
    else $error("APB ready timing wrong");
  err_ready_a: assert property (pslverr_out |-> pready_out)
    else $error("Slave error without ready");
  strobe_cause_a: assert property (cmd_strobe_out |-> $past(cmd_valid_in && command_ready_output_out))
    else $error("Command taken while not ready");
  speed_cmd_a: assert property (cmd_strobe_out && cmd_kind_out == 2'h1 |-> speed_ref_out == cmd_value_out)
    else $error("Speed command not applied");
  locked_out_a: assert property (!command_ready_output_out |=> !cmd_strobe_out)
    else $error("Command taken while locked");
  ready_power_a: assert property ($rose(command_ready_output_out) |-> $rose(power_stage_on_out))
    else $error("Ready without fresh power");
  fault_stop_a: assert property (command_ready_output_out && fault_in |=> !command_ready_output_out)
    else $error("Fault did not stop");
  estop_stop_a: assert property (command_ready_output_out && emergency_stop_function_in |-> ##[1:4] !command_ready_output_out)
    else $error("Emergency stop ignored");
  off_zero_a: assert property ($fell(power_stage_on_out) |-> speed_ref_out == 16'h0000)
    else $error("Power off with speed left");
  ramp_step_a: assert property (power_stage_on_out && !command_ready_output_out && prev_power |-> cur == prev_speed
    || (prev_speed > 16'sh0 && cur == prev_speed - 16'sh1) || (prev_speed < 16'sh0 && cur == prev_speed + 16'sh1))
    else $error("Ramp step too large");
  cover property (cmd_strobe_out);
  cover property (power_stage_on_out && !command_ready_output_out && speed_ref_out != 16'h0000);
  cover property (power_stage_on_out && !command_ready_output_out && speed_ref_out == 16'h0000);
endmodule
bind servo_enable_stop_sequencer servo_stop_checker u_servo_stop_checker (.core_clk_in, .reset_in, .psel_in,
  .penable_in, .emergency_stop_function_in, .fault_in, .cmd_valid_in, .pready_out, .pslverr_out,
  .command_ready_output_out, .power_stage_on_out, .speed_ref_out, .cmd_strobe_out, .cmd_kind_out, .cmd_value_out);
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the servo enable and stop sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import servo_stop_pkg::*;
  logic clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, fault = 1'h0, e;
  logic run_req = 1'h0, estop_req = 1'h0, cmd_req = 1'h0, pready, pslverr, ready, power, strobe, irq;
  logic run_en, estop, cval;
  logic [1:0] ckind, okind, hkind = 2'h1;
  logic [7:0] paddr = 8'h00;
  logic [15:0] speed, cvalue, hvalue = 16'h0000, cmd_val;
  logic [31:0] pwdata = 32'h0, prdata, q;
  int n_errors = 0, checks = 0, n_strobe = 0, c;
  servo_enable_stop_sequencer u_servo_enable_stop_sequencer (.core_clk_in(clk), .reset_in(rst),
    .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .pready_out(pready), .pslverr_out(pslverr), .prdata_out(prdata), .run_enable_function_in(run_en),
    .emergency_stop_function_in(estop), .fault_in(fault), .cmd_valid_in(cval), .cmd_kind_in(ckind),
    .cmd_value_in(cvalue), .command_ready_output_out(ready), .power_stage_on_out(power),
    .speed_ref_out(speed), .cmd_strobe_out(strobe), .cmd_kind_out(okind), .cmd_value_out(cmd_val), .irq_out(irq));
  host_model u_host_model (.clk_in(clk), .run_req_in(run_req), .estop_req_in(estop_req), .cmd_req_in(cmd_req),
    .kind_in(hkind), .value_in(hvalue), .run_enable_out(run_en), .estop_out(estop), .cmd_valid_out(cval),
    .kind_out(ckind), .value_out(cvalue));
  initial begin
    forever #12.5 clk = ~clk;
  end
  // Accepted commands are counted so refusals show up later
  always @(posedge clk) if (strobe === 1'h1) n_strobe <= n_strobe + 1;
  task final_report;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string nm);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Bounded waits end the run instead of hanging
  task tmo(input int lim);
    chk(c < lim, 1, "wait bound");
    if (c >= lim) final_report();
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    for (c = 0; c < 20 && pready !== 1'h1; c++) @(posedge clk);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    tmo(20);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'h0, a, 32'h0);
    chk(q, x, "register");
  endtask
  task automatic wait_bit(ref logic s, input logic v, input int lim);
    for (c = 0; c < lim && s !== v; c++) @(posedge clk);
    tmo(lim);
  endtask
  task automatic cmd(input logic [1:0] k, input logic [15:0] v);
    @(posedge clk);
    cmd_req <= 1'h1;
    hkind <= k;
    hvalue <= v;
    @(posedge clk);
    cmd_req <= 1'h0;
    repeat (3) @(posedge clk);
  endtask
  task automatic irq_is(input logic v);
    repeat (2) @(posedge clk);
    chk(irq, v, "irq");
  endtask
  task t_regs;
    rd(OFS_DISABLE_STOP_METHOD, 32'h0);
    rd(OFS_ESTOP_STOP_METHOD, 32'h0);
    rd(OFS_FAST_STOP_TIME_MS, 32'h1F4);
    rd(OFS_SLOW_STOP_TIME_MS, 32'h3E8);
    apb(1'h1, OFS_DISABLE_STOP_METHOD, 32'h3);
    rd(OFS_DISABLE_STOP_METHOD, 32'h0);
    for (int k = 0; k < 6; k++) begin
      apb(1'h1, OFS_ESTOP_STOP_METHOD, k);
      rd(OFS_ESTOP_STOP_METHOD, k < 5 ? k : 4);
    end
    apb(1'h0, 8'h28, 32'h0);
    chk(e, 1, "slave error");
    $display("test regs done");
  endtask
  task t_run;
    apb(1'h1, OFS_RATED_SPEED, 32'hFA0);
    apb(1'h1, OFS_FAST_STOP_TIME_MS, 32'h1);
    apb(1'h1, OFS_SLOW_STOP_TIME_MS, 32'h2);
    cmd(2'h1, 16'h0014);
    chk(n_strobe, 0, "early strobe");
    run_req <= 1'h1;
    wait_bit(ready, 1'h1, 20);
    for (int k = 2; k >= 0; k--) cmd(k, 16'h0014);
    chk(n_strobe, 3, "strobes");
    chk(speed, 16'h0014, "speed ref");
    chk(cmd_val, 16'h0014, "cmd value");
    chk(okind, 2'h0, "cmd kind");
    $display("test run done");
  endtask
  task t_coast;
    run_req <= 1'h0;
    wait_bit(power, 1'h0, 6);
    chk(speed, 16'h0000, "coast speed");
    $display("test coast done");
  endtask
  // Slow ramp of 20 units at 4000 rated over 2 ms: 400 cycles, hold afterwards
  task t_hold;
    apb(1'h1, OFS_DISABLE_STOP_METHOD, 32'h1);
    run_req <= 1'h1;
    wait_bit(ready, 1'h1, 20);
    cmd(2'h1, 16'h0014);
    estop_req <= 1'h1;
    wait_bit(ready, 1'h0, 8);
    for (c = 0; c < 600 && speed !== 16'h0000; c++) begin
      @(posedge clk);
      chk(power, 1, "ramp power");
    end
    chk(c > 390 && c < 410, 1, "slow ramp time");
    repeat (5) @(posedge clk);
    chk({power, ready}, 2'h2, "hold state");
    cmd(2'h1, 16'h0005);
    chk(n_strobe, 4, "hold refusal");
    estop_req <= 1'h0;
    repeat (5) @(posedge clk);
    chk(power, 1, "still held");
    run_req <= 1'h0;
    wait_bit(power, 1'h0, 8);
    $display("test hold done");
  endtask
  // Fault method fast-then-off: 200 cycles, then interrupt set, masked and cleared
  task t_fault;
    apb(1'h1, OFS_INT_CLEAR, 32'hF);
    apb(1'h1, OFS_INT_ENABLE, 32'h4);
    apb(1'h1, OFS_DRIVE_CONTROL, 32'h11);
    wait_bit(ready, 1'h1, 20);
    cmd(2'h1, 16'h0014);
    fault <= 1'h1;
    for (c = 0; c < 400 && power !== 1'h0; c++) @(posedge clk);
    chk(c > 190 && c < 215, 1, "fast ramp time");
    irq_is(1'h1);
    apb(1'h1, OFS_INT_ENABLE, 32'h0);
    irq_is(1'h0);
    apb(1'h1, OFS_INT_ENABLE, 32'h4);
    irq_is(1'h1);
    apb(1'h1, OFS_INT_CLEAR, 32'h4);
    irq_is(1'h0);
    rd(OFS_INT_STATUS, 32'h3);
    rd(OFS_DRIVE_CONTROL, 32'h11);
    rd(OFS_DRIVE_STATUS, 32'h1);
    apb(1'h1, OFS_DRIVE_CONTROL, 32'h0);
    fault <= 1'h0;
    $display("test fault done");
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'h0;
    t_regs();
    t_run();
    t_coast();
    t_hold();
    t_fault();
    final_report();
  end
endmodule
`default_nettype wire
